// file: rtl/pmc_pkg.sv
// shared constants, types and register map of the power mode controller
package pmc_pkg;

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_SLEEP_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_RTC_LO    = 8'h0C;
    localparam logic [7:0] ADDR_RTC_HI    = 8'h10;
    localparam logic [7:0] ADDR_CMP_LO    = 8'h14;
    localparam logic [7:0] ADDR_CMP_HI    = 8'h18;
    localparam logic [7:0] ADDR_SLOW_INC  = 8'h1C;
    localparam logic [7:0] ADDR_ID        = 8'h20;
    // retained memory occupies every address with bit 7 set
    localparam int unsigned MEM_SEL_BIT   = 7;

    // ---------------------------------------------------------------
    // control and status register fields
    // ---------------------------------------------------------------
    localparam int unsigned CTRL_SLEEP_GO   = 0;
    localparam int unsigned CTRL_AUTO_SLOW  = 1;
    localparam int unsigned CTRL_PIN_EN     = 2;
    localparam int unsigned CTRL_PIN_LEVEL  = 3;
    localparam int unsigned CTRL_TIMER_EN   = 4;
    localparam int unsigned STAT_STATE_LSB  = 0;
    localparam int unsigned STAT_PEND       = 4;
    localparam int unsigned STAT_WAKE_PIN   = 5;
    localparam int unsigned STAT_WAKE_TIMER = 6;
    localparam int unsigned STAT_FAULT      = 7;

    // ---------------------------------------------------------------
    // reset values and sizes
    // ---------------------------------------------------------------
    localparam int unsigned NUM_SUPPLIES   = 3;
    localparam int unsigned RTC_W          = 64;
    localparam int unsigned MEM_BYTES      = 128;
    localparam logic [7:0]  SLEEP_CFG_RST  = 8'h07;
    localparam logic [31:0] SLOW_INC_RST   = 32'h0000_0140;
    // arbitrary neutral value, names no real part
    localparam logic [31:0] BLOCK_ID       = 32'h0000_A5A5;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned SLOW_OSC_HZ = 31_250;
    localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_OSC_HZ;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        PMC_AWAKE   = 4'h0,
        PMC_S_CLK   = 4'h1,
        PMC_S_RST   = 4'h2,
        PMC_S_SUP   = 4'h3,
        PMC_ASLEEP  = 4'h4,
        PMC_W_SUP   = 4'h5,
        PMC_W_RST   = 4'h6,
        PMC_W_CLK   = 4'h7
    } pmc_state_type;

    typedef struct packed {
        logic                    rst_assert;
        logic                    clk_mask;
        logic [NUM_SUPPLIES-1:0] pulse_skip;
        logic [NUM_SUPPLIES-1:0] supply_en;
    } pmc_sleep_cfg_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } pmc_bus_req_type;

endpackage

// file: rtl/pmc_ctrl.sv
// power mode controller with real-time counter and retained memory
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module pmc_ctrl
#(
    parameter int unsigned MEM_WORDS = pmc_pkg::MEM_BYTES / 4
)
(
    // clock and reset
    input  wire logic                                i_core_clk,
    input  wire logic                                i_rst,
    // register port
    input  wire pmc_pkg::pmc_bus_req_type            i_bus,
    output logic [pmc_pkg::DATA_W-1:0]               o_rdata,
    // wake pin and supply status
    input  wire logic                                i_wake_pin,
    input  wire logic [pmc_pkg::NUM_SUPPLIES-1:0]    i_pgood,
    // power controls
    output logic [pmc_pkg::NUM_SUPPLIES-1:0]         o_supply_en,
    output logic [pmc_pkg::NUM_SUPPLIES-1:0]         o_pulse_skip,
    output logic                                     o_clock_mask,
    output logic                                     o_core_reset,
    output logic                                     o_digital_node_on,
    output logic                                     o_switched_io_supply,
    output logic                                     o_watchdog_en,
    output logic                                     o_rtc_slow,
    output logic                                     o_sys_reset
);
    import pmc_pkg::*;

    // the word index is five address bits wide
    if (MEM_WORDS < 1 || MEM_WORDS > 32)
    begin : g_bad_mem_words
        $error("MEM_WORDS must be 1 to 32");
    end

    localparam logic [NUM_SUPPLIES-1:0] ALL_ON  = '1;
    localparam logic [8:0]              DIV_MAX = 9'(SLOW_DIV - 1);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    pmc_state_type           state, next_state;
    pmc_sleep_cfg_type       sleep_cfg;
    logic                    auto_slow, pin_en, pin_level, timer_en;
    logic                    wake_pend, wake_by_pin, wake_by_timer, fault_flag;
    logic [RTC_W-1:0]        rtc, cmp;
    logic [31:0]             slow_inc, rtc_hi_snap;
    logic [8:0]              div_cnt;
    logic                    slow_tick;
    logic [NUM_SUPPLIES-1:0] pg_q;
    logic [DATA_W-1:0]       mem [0:MEM_WORDS-1];
    logic [DATA_W-1:0]       next_rdata;
    logic                    wr_ctrl, sleep_go, pin_hit, cmp_hit;
    logic                    in_transit, pg_fault, mem_sel;
    logic [4:0]              mem_idx;

    assign wr_ctrl    = i_bus.wr && (i_bus.addr == ADDR_CTRL);
    // accepted only while awake, any other time the strobe is dropped
    assign sleep_go   = wr_ctrl && i_bus.wdata[CTRL_SLEEP_GO];
    assign pin_hit    = pin_en && (i_wake_pin == pin_level);
    assign cmp_hit    = timer_en && (rtc >= cmp);
    assign in_transit = (state != PMC_AWAKE) && (state != PMC_ASLEEP);
    // a supply that was good and is still meant to be on went bad
    assign pg_fault   = in_transit && |(pg_q & ~i_pgood & o_supply_en);
    assign mem_sel    = i_bus.addr[MEM_SEL_BIT];
    assign mem_idx    = i_bus.addr[6:2];

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            PMC_AWAKE:
                if (sleep_go)
                    next_state = PMC_S_CLK;
            PMC_S_CLK:
                next_state = PMC_S_RST;
            PMC_S_RST:
                next_state = PMC_S_SUP;
            PMC_S_SUP:
                // only the supplies kept on need to report good
                if ((i_pgood & o_supply_en) == o_supply_en)
                    next_state = PMC_ASLEEP;
            PMC_ASLEEP:
                if (wake_pend || pin_hit || cmp_hit)
                    next_state = PMC_W_SUP;
            PMC_W_SUP:
                if (i_pgood == ALL_ON)
                    next_state = PMC_W_RST;
            PMC_W_RST:
                next_state = PMC_W_CLK;
            PMC_W_CLK:
                next_state = PMC_AWAKE;
            default:
                next_state = PMC_AWAKE;
        endcase
        if (pg_fault)
            next_state = PMC_AWAKE;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            state <= PMC_AWAKE;
        else
            state <= next_state;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            pg_q <= '0;
        else
            pg_q <= i_pgood;
    end

    // ---------------------------------------------------------------
    // power outputs, driven from the state being entered, except o_sys_reset from pg_fault
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_supply_en          <= ALL_ON;
            o_pulse_skip         <= '0;
            o_clock_mask         <= 1'b0;
            o_core_reset         <= 1'b0;
            o_digital_node_on    <= 1'b1;
            o_switched_io_supply <= 1'b1;
            o_watchdog_en        <= 1'b1;
            o_rtc_slow           <= 1'b0;
            o_sys_reset          <= 1'b0;
        end
        else
        begin
            o_switched_io_supply <= (next_state == PMC_AWAKE);
            o_watchdog_en        <= (next_state == PMC_AWAKE);
            o_digital_node_on    <= (next_state != PMC_ASLEEP);
            o_rtc_slow           <= (next_state == PMC_ASLEEP) && auto_slow;
            o_sys_reset          <= pg_fault;
            case (next_state)
                PMC_S_CLK:
                    o_clock_mask <= sleep_cfg.clk_mask;
                PMC_W_RST:
                    o_core_reset <= 1'b0;
                PMC_S_RST:
                    o_core_reset <= sleep_cfg.rst_assert;
                PMC_S_SUP:
                begin
                    o_supply_en  <= sleep_cfg.supply_en;
                    o_pulse_skip <= sleep_cfg.pulse_skip;
                end
                PMC_W_SUP:
                begin
                    o_supply_en  <= ALL_ON;
                    o_pulse_skip <= '0;
                end
                PMC_W_CLK:
                    o_clock_mask <= 1'b0;
                PMC_AWAKE:
                begin
                    o_supply_en  <= ALL_ON;
                    o_pulse_skip <= '0;
                    o_clock_mask <= 1'b0;
                    o_core_reset <= 1'b0;
                end
                default:
                    o_supply_en  <= o_supply_en;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // wake capture
    // ---------------------------------------------------------------
    // held from sleep entry on so a stimulus during entry is not lost
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            wake_pend <= 1'b0;
        else if (next_state == PMC_AWAKE)
            wake_pend <= 1'b0;
        else
            wake_pend <= wake_pend || pin_hit || cmp_hit;
    end

    // cause flags are sticky; a new cause wins over a clearing write
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wake_by_pin   <= 1'b0;
            wake_by_timer <= 1'b0;
            fault_flag    <= 1'b0;
        end
        else
        begin
            if (state == PMC_ASLEEP && next_state == PMC_W_SUP)
            begin
                wake_by_pin   <= wake_by_pin || pin_hit;
                wake_by_timer <= wake_by_timer || cmp_hit;
            end
            else if (i_bus.wr && i_bus.addr == ADDR_STATUS)
            begin
                wake_by_pin   <= wake_by_pin && !i_bus.wdata[STAT_WAKE_PIN];
                wake_by_timer <= wake_by_timer && !i_bus.wdata[STAT_WAKE_TIMER];
            end
            if (pg_fault)
                fault_flag <= 1'b1;
            else if (i_bus.wr && i_bus.addr == ADDR_STATUS && i_bus.wdata[STAT_FAULT])
                fault_flag <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // real-time counter
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_cnt   <= '0;
            slow_tick <= 1'b0;
        end
        else
        begin
            slow_tick <= (div_cnt == DIV_MAX);
            div_cnt   <= (div_cnt == DIV_MAX) ? 9'h000 : div_cnt + 9'h001;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            rtc <= '0;
        else if (o_rtc_slow)
        begin
            if (slow_tick)
                rtc <= rtc + {32'h0000_0000, slow_inc};
        end
        else
            rtc <= rtc + 64'h0000_0000_0000_0001;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            auto_slow <= 1'b0;
            pin_en    <= 1'b0;
            pin_level <= 1'b0;
            timer_en  <= 1'b0;
            sleep_cfg <= SLEEP_CFG_RST;
            cmp       <= '1;
            slow_inc  <= SLOW_INC_RST;
        end
        else if (i_bus.wr)
        begin
            case (i_bus.addr)
                ADDR_CTRL:
                begin
                    auto_slow <= i_bus.wdata[CTRL_AUTO_SLOW];
                    pin_en    <= i_bus.wdata[CTRL_PIN_EN];
                    pin_level <= i_bus.wdata[CTRL_PIN_LEVEL];
                    timer_en  <= i_bus.wdata[CTRL_TIMER_EN];
                end
                ADDR_SLEEP_CFG: sleep_cfg     <= i_bus.wdata[7:0];
                ADDR_CMP_LO:    cmp[31:0]     <= i_bus.wdata;
                ADDR_CMP_HI:    cmp[63:32]    <= i_bus.wdata;
                ADDR_SLOW_INC:  slow_inc      <= i_bus.wdata;
                default:        slow_inc      <= slow_inc;
            endcase
        end
    end

    // retained words are never reset so they survive sleep and fault resets
    always_ff @(posedge i_core_clk)
    begin
        if (i_bus.wr && mem_sel && (32'(mem_idx) < MEM_WORDS))
            mem[mem_idx] <= i_bus.wdata;
    end

    // reading the low word freezes the high word for a coherent pair
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            rtc_hi_snap <= '0;
        else if (i_bus.rd && i_bus.addr == ADDR_RTC_LO)
            rtc_hi_snap <= rtc[63:32];
    end

    always_comb
    begin
        next_rdata = '0;
        if (mem_sel && (32'(mem_idx) < MEM_WORDS))
            next_rdata = mem[mem_idx];
        else
        begin
            case (i_bus.addr)
                ADDR_CTRL:
                    next_rdata = {27'h0000000, timer_en, pin_level, pin_en,
                                  auto_slow, 1'b0};
                ADDR_SLEEP_CFG: next_rdata = {24'h000000, sleep_cfg};
                ADDR_STATUS:
                    next_rdata = {24'h000000, fault_flag, wake_by_timer,
                                  wake_by_pin, wake_pend, state};
                ADDR_RTC_LO:    next_rdata = rtc[31:0];
                ADDR_RTC_HI:    next_rdata = rtc_hi_snap;
                ADDR_CMP_LO:    next_rdata = cmp[31:0];
                ADDR_CMP_HI:    next_rdata = cmp[63:32];
                ADDR_SLOW_INC:  next_rdata = slow_inc;
                ADDR_ID:        next_rdata = BLOCK_ID;
                default:        next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= '0;
        else if (i_bus.rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= '0;
    end

endmodule // pmc_ctrl

`default_nettype wire

// file: bench/pmc_ctrl_props.sv
// concurrent checks on the ports of the power mode controller
`timescale 1ns/10ps
`default_nettype none

module pmc_ctrl_props
    import pmc_pkg::*;
#(
    parameter int unsigned MEM_WORDS = MEM_BYTES / 4
)
(
    // clock and reset
    input wire logic                    i_core_clk,
    input wire logic                    i_rst,
    // register port
    input wire pmc_bus_req_type         i_bus,
    input wire logic [DATA_W-1:0]       o_rdata,
    // wake pin and supply status
    input wire logic                    i_wake_pin,
    input wire logic [NUM_SUPPLIES-1:0] i_pgood,
    // power controls
    input wire logic [NUM_SUPPLIES-1:0] o_supply_en,
    input wire logic [NUM_SUPPLIES-1:0] o_pulse_skip,
    input wire logic                    o_clock_mask,
    input wire logic                    o_core_reset,
    input wire logic                    o_digital_node_on,
    input wire logic                    o_switched_io_supply,
    input wire logic                    o_watchdog_en,
    input wire logic                    o_rtc_slow,
    input wire logic                    o_sys_reset
);
    // ---------------------------------------------------------------
    // shadow of the software settings
    // ---------------------------------------------------------------
    logic [7:0] cfg;
    logic [4:0] ctl;
    logic       rd_q;
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
            cfg <= SLEEP_CFG_RST;
        else if (i_bus.wr && i_bus.addr == ADDR_SLEEP_CFG)
            cfg <= i_bus.wdata[7:0];
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
            ctl <= '0;
        else if (i_bus.wr && i_bus.addr == ADDR_CTRL)
            ctl <= i_bus.wdata[4:0];
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
            rd_q <= 1'b0;
        else
            rd_q <= i_bus.rd;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_go;
        i_bus.wr && i_bus.addr == ADDR_CTRL && i_bus.wdata[CTRL_SLEEP_GO] && o_watchdog_en;
    endsequence
    sequence s_enter;
        o_clock_mask == cfg[6] ##1 o_core_reset == cfg[7]
        ##1 o_supply_en == cfg[2:0] && o_pulse_skip == cfg[5:3];
    endsequence

    AST_ENTRY_ORDER: assert property (s_go |=> s_enter)
        else $error("sleep entry steps out of order");
    AST_ENTRY_HOLD: assert property (s_go |=> (!o_watchdog_en && o_digital_node_on) [*3])
        else $error("sleep entry cut short");
    AST_AWAKE_PAIR: assert property (o_watchdog_en == o_switched_io_supply)
        else $error("watchdog and io supply disagree");
    AST_GATED: assert property ($fell(o_digital_node_on) |->
        $past((i_pgood & o_supply_en) == o_supply_en))
        else $error("asleep before supplies good");
    AST_WAKE_UP: assert property ($rose(o_digital_node_on) |->
        o_supply_en == 3'h7 && o_pulse_skip == 3'h0 && !o_rtc_slow)
        else $error("wake did not restore supplies");
    AST_PIN_WAKE: assert property (!o_digital_node_on && ctl[2] &&
        i_wake_pin == ctl[3] |=> o_digital_node_on)
        else $error("pin wake ignored");
    AST_SLOW_SRC: assert property (!o_digital_node_on |-> o_rtc_slow == ctl[1])
        else $error("counter source wrong in sleep");
    AST_FAULT: assert property (!o_watchdog_en && o_digital_node_on
        && |(o_supply_en & $past(i_pgood) & ~i_pgood) |=> o_sys_reset && o_watchdog_en)
        else $error("power good loss not reset");
    AST_PULSE: assert property (o_sys_reset |=> !o_sys_reset)
        else $error("system reset longer than a cycle");
    AST_RELEASE: assert property ($fell(o_clock_mask) && !o_sys_reset
        |=> o_watchdog_en && !o_core_reset)
        else $error("clock unmasked out of order");
    AST_RDATA_IDLE: assert property (!rd_q |-> o_rdata == '0)
        else $error("read data outside its cycle");
endmodule // pmc_ctrl_props

bind pmc_ctrl pmc_ctrl_props #(.MEM_WORDS(MEM_WORDS)) u_props (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_wake_pin(i_wake_pin), .i_pgood(i_pgood), .o_supply_en(o_supply_en),
    .o_pulse_skip(o_pulse_skip), .o_clock_mask(o_clock_mask), .o_core_reset(o_core_reset),
    .o_digital_node_on(o_digital_node_on), .o_switched_io_supply(o_switched_io_supply),
    .o_watchdog_en(o_watchdog_en), .o_rtc_slow(o_rtc_slow), .o_sys_reset(o_sys_reset));
`default_nettype wire

// file: bench/pmc_supply_model.sv
// supplies with delayed power-good on the far side of the controller
`timescale 1ns/10ps
`default_nettype none

module pmc_supply_model
    import pmc_pkg::*;
#(
    parameter int unsigned DLY = 4
)
(
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst,
    input  wire logic [NUM_SUPPLIES-1:0] i_supply_en,
    input  wire logic [NUM_SUPPLIES-1:0] i_drop,
    output logic      [NUM_SUPPLIES-1:0] o_pgood
);
    logic [NUM_SUPPLIES-1:0] hist [DLY];
    logic [NUM_SUPPLIES-1:0] held;
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
            hist <= '{default: '1};
        else
        begin
            hist[0] <= i_supply_en;
            for (int k = 1; k < DLY; k++)
                hist[k] <= hist[k-1];
        end
    // good only once enabled DLY cycles in a row; no stale good after a re-enable
    always_comb
    begin
        held = i_supply_en;
        for (int k = 0; k < DLY; k++)
            held = held & hist[k];
    end
    assign o_pgood = held & ~i_drop;
endmodule // pmc_supply_model
`default_nettype wire

// file: bench/pmc_ctrl_test.sv
// self-checking bench for the power mode controller
`timescale 1ns/10ps
`default_nettype none

module pmc_ctrl_test;
    import pmc_pkg::*;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    pin = 1'b0;
    logic [NUM_SUPPLIES-1:0] drop = '0;
    pmc_bus_req_type         req = '0;
    logic [DATA_W-1:0]       rdata;
    logic [NUM_SUPPLIES-1:0] pgood, sup_en, skip;
    logic                    mask, core_rst, node_on, io_on, wdog, slow, sys_rst;
    int                      fails = 0;
    int                      cmp_count = 0;

    always #50 clk = ~clk;

    pmc_ctrl uut (
        .i_core_clk(clk), .i_rst(rst), .i_bus(req), .o_rdata(rdata), .i_wake_pin(pin),
        .i_pgood(pgood), .o_supply_en(sup_en), .o_pulse_skip(skip), .o_clock_mask(mask),
        .o_core_reset(core_rst), .o_digital_node_on(node_on), .o_switched_io_supply(io_on),
        .o_watchdog_en(wdog), .o_rtc_slow(slow), .o_sys_reset(sys_rst));
    pmc_supply_model #(.DLY(4)) supplies (.i_core_clk(clk), .i_rst(rst),
        .i_supply_en(sup_en), .i_drop(drop), .o_pgood(pgood));

    // ---------------------------------------------------------------
    // bus and checking helpers
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // polls once a cycle; a bound that runs out ends the run
    task automatic wait_for(input string name, ref logic sig, input logic val, input int bound);
        int n = 0;
        while (sig !== val && n < bound)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(name, sig, val);
        if (sig !== val)
            tally_and_finish();
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        rd(ADDR_SLEEP_CFG, d);
        chk("sleep_cfg", d, SLEEP_CFG_RST);
        rd(ADDR_SLOW_INC, d);
        chk("slow_inc", d, SLOW_INC_RST);
        rd(ADDR_STATUS, d);
        chk("status", d, 32'h0000_0000);
        rd(8'h24, d);
        chk("unmapped", d, 32'h0000_0000);
        chk("awake_outs", {node_on, io_on, wdog, sup_en}, 6'h3F);
        wr(8'h84, 32'h1234_ABCD);
        $display("reset test done");
    endtask
    task automatic t_rtc();
        logic [31:0] a, b;
        rd(ADDR_RTC_LO, a);
        rd(ADDR_RTC_LO, b);
        chk("rtc_rate", b - a, 32'h0000_0002);
        rd(ADDR_RTC_HI, b);
        chk("rtc_hi", b, 32'h0000_0000);
        $display("counter test done");
    endtask
    task automatic t_pin();
        logic [31:0] d;
        wr(ADDR_SLEEP_CFG, 32'h0000_00FA);
        wr(ADDR_CTRL, 32'h0000_000F);
        pin <= 1'b1;
        wait_for("asleep", node_on, 1'b0, 20);
        chk("sleep_outs", {slow, mask, core_rst, skip, sup_en}, 9'h1FA);
        chk("sleep_gates", {io_on, wdog}, 2'h0);
        @(posedge clk);
        #1;
        chk("held_wake", node_on, 1'b1);
        wait_for("awake", wdog, 1'b1, 30);
        pin <= 1'b0;
        chk("woke_outs", {mask, core_rst, sup_en}, 5'h07);
        rd(ADDR_STATUS, d);
        chk("status_pin", d[7:0], 8'h20);
        rd(8'h84, d);
        chk("retained", d, 32'h1234_ABCD);
        wr(ADDR_STATUS, 32'h0000_00E0);
        $display("pin wake test done");
    endtask
    task automatic t_timer();
        logic [31:0] v, d;
        wr(ADDR_SLOW_INC, 32'h0000_1000);
        rd(ADDR_RTC_LO, v);
        wr(ADDR_CMP_HI, 32'h0000_0000);
        wr(ADDR_CMP_LO, v + 32'd1500);
        wr(ADDR_CTRL, 32'h0000_0013);
        wait_for("asleep", node_on, 1'b0, 20);
        chk("slow_src", slow, 1'b1);
        // one slow step jumps past the compare value, so only a >= test wakes
        wait_for("timer_wake", node_on, 1'b1, 400);
        wait_for("awake", wdog, 1'b1, 30);
        rd(ADDR_RTC_LO, d);
        chk("slow_step", (d - v) >= 32'd4096, 1'b1);
        rd(ADDR_STATUS, d);
        chk("status_tmr", d[7:0], 8'h40);
        $display("timer wake test done");
    endtask
    task automatic t_fault();
        logic [31:0] d;
        wr(ADDR_STATUS, 32'h0000_00E0);
        wr(ADDR_CTRL, 32'h0000_0005);
        wait_for("asleep", node_on, 1'b0, 20);
        wait_for("waking", node_on, 1'b1, 3);
        @(posedge clk);
        drop <= 3'h2;
        wait_for("sys_reset", sys_rst, 1'b1, 3);
        chk("fault_awake", wdog, 1'b1);
        @(posedge clk);
        drop <= 3'h0;
        #1;
        chk("reset_pulse", sys_rst, 1'b0);
        rd(ADDR_STATUS, d);
        chk("status_flt", d[7:0] & 8'h8F, 8'h80);
        wr(ADDR_STATUS, 32'h0000_0080);
        rd(ADDR_STATUS, d);
        chk("flt_clear", d[7], 1'b0);
        $display("fault test done");
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_rtc();
        t_pin();
        t_timer();
        t_fault();
        tally_and_finish();
    end
endmodule // pmc_ctrl_test
`default_nettype wire
